// file: epc_regs.sv
// identity word and exception pending control word with bus slave
`timescale 1ns/100ps
module epc_regs
  import epc_pkg::*;
#(
  parameter logic [7:0]  IMPL_CODE   = EPC_IMPL_DEF,
  parameter logic [3:0]  VARIANT_N   = EPC_VARIANT_DEF,
  parameter logic [11:0] PART_NUMBER = EPC_PART_DEF,
  parameter logic [3:0]  REVISION_M  = EPC_REV_DEF
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  input  wire epc_bus_req_t bus_req,
  output logic [31:0]       rd_data,
  input  wire logic         sec_state,
  input  wire logic         nmi_req,
  input  wire logic         tick_event,
  input  wire logic         irq_pending,
  input  wire logic [8:0]   irq_number,
  input  wire logic [7:0]   irq_priority,
  input  wire logic [7:0]   svc_priority,
  input  wire logic [7:0]   tick_priority,
  input  wire logic [7:0]   base_priority_mask,
  input  wire logic         fault_mask_a,
  input  wire logic [8:0]   active_vector_number,
  input  wire logic [7:0]   active_count,
  output logic              nmi_pending,
  output logic [1:0]        svc_pending,
  output logic [1:0]        tick_pending,
  output logic [8:0]        pending_vector_number
);

  // ************************************************************
  // address decode
  // ************************************************************

  logic        wr_ctrl;
  logic        rd_ident;
  logic        rd_ctrl;
  logic [31:0] wd;
  logic [31:0] ident_word;
  logic [31:0] ctrl_word;
  logic [31:0] rd_data_next;
  logic [8:0]  vec_sel;
  logic        svc_any;
  logic        tick_any;

  // writes to the identity word fall through: it is read-only
  assign wr_ctrl  = bus_req.wr && (bus_req.addr == EPC_OFS_CTRL);
  assign rd_ident = bus_req.rd && (bus_req.addr == EPC_OFS_IDENT);
  assign rd_ctrl  = bus_req.rd && (bus_req.addr == EPC_OFS_CTRL);
  assign wd       = bus_req.wdata;

  // ************************************************************
  // identity word
  // ************************************************************

  // one copy only; the security state never selects it
  assign ident_word = {IMPL_CODE, VARIANT_N, EPC_CONST_NIB,
                       PART_NUMBER, REVISION_M};

  // ************************************************************
  // pending flags
  // ************************************************************

  // nonmaskable pending is shared by both states
  epc_pend_flag u_nmi (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .set_sw  (wr_ctrl && wd[EPC_B_NMI_SET]),
    .set_hw  (nmi_req),
    .clr_sw  (wr_ctrl && wd[EPC_B_NMI_CLR]),
    .flag    (nmi_pending)
  );

  // service call and tick bits are banked one per security state;
  // a write only touches the bank of the state that issues it
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      logic mine;
      assign mine = wr_ctrl && (sec_state == 1'(gb));

      // no hardware source may pend the service call
      epc_pend_flag u_svc (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .set_sw  (mine && wd[EPC_B_SVC_SET]),
        .set_hw  (1'b0),
        .clr_sw  (mine && wd[EPC_B_SVC_CLR]),
        .flag    (svc_pending[gb])
      );

      // the tick timer event lands in the bank of the current state
      epc_pend_flag u_tick (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .set_sw  (mine && wd[EPC_B_TICK_SET]),
        .set_hw  (tick_event && (sec_state == 1'(gb))),
        .clr_sw  (mine && wd[EPC_B_TICK_CLR]),
        .flag    (tick_pending[gb])
      );
    end
  endgenerate

  // ************************************************************
  // pending vector selection
  // ************************************************************

  assign svc_any  = |svc_pending;
  assign tick_any = |tick_pending;

  epc_vector_sel u_sel (
    .nmi_p      (nmi_pending),
    .svc_p      (svc_any),
    .tick_p     (tick_any),
    .irq_p      (irq_pending),
    .irq_num    (irq_number),
    .svc_prio   (svc_priority),
    .tick_prio  (tick_priority),
    .irq_prio   (irq_priority),
    .base_prio  (base_priority_mask),
    .fault_mask (fault_mask_a),
    .vec        (vec_sel)
  );

  // registered copy for the core; the read path uses the live value
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_vector_number <= 9'h000;
    end else begin
      pending_vector_number <= vec_sel;
    end
  end

  // ************************************************************
  // control word read image
  // ************************************************************

  // clear bits and the reserved bit read zero; the tick clear bit
  // has no defined read value, zero is simply the cheapest choice
  always_comb begin
    ctrl_word = EPC_RST_WORD;
    ctrl_word[EPC_B_NMI_SET]  = nmi_pending;
    ctrl_word[EPC_B_RSVD]     = 1'b0;
    ctrl_word[EPC_B_SVC_SET]  = svc_pending[sec_state];
    ctrl_word[EPC_B_TICK_SET] = tick_pending[sec_state];
    ctrl_word[EPC_B_ISR_PEND] = irq_pending;
    ctrl_word[EPC_VPEND_LSB +: EPC_VEC_W] = vec_sel;
    ctrl_word[EPC_B_RETBASE]  = (active_count <= 8'h01);
    ctrl_word[EPC_VACT_LSB +: EPC_VEC_W] = active_vector_number;
  end

  // ************************************************************
  // read data
  // ************************************************************

  // unmapped reads and idle cycles give zero
  always_comb begin
    rd_data_next = EPC_RST_WORD;
    if (rd_ident) begin
      rd_data_next = ident_word;
    end else if (rd_ctrl) begin
      rd_data_next = ctrl_word;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= EPC_RST_WORD;
    end else begin
      rd_data <= rd_data_next;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence ctrl_wr(int b);
    wr_ctrl && wd[b];
  endsequence

  sequence ctrl_rd_in(logic s);
    rd_ctrl && (sec_state == s);
  endsequence

  sequence no_svc_set;
    !(wr_ctrl && wd[EPC_B_SVC_SET]);
  endsequence

  sequence bank_wr(logic s);
    wr_ctrl && (sec_state == s);
  endsequence

  // helper for the shared identity check: the first identity read after
  // reset is kept, and every later one, from either state, must match it
  logic        ident_rd_d_reg;
  logic        ident_seen_reg;
  logic [31:0] ident_first_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ident_rd_d_reg <= 1'b0;
    end else begin
      ident_rd_d_reg <= rd_ident;
    end
  end

  // only the first read is captured, so a later wrong word cannot hide
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ident_seen_reg  <= 1'b0;
      ident_first_reg <= 32'h0000_0000;
    end else if (ident_rd_d_reg && !ident_seen_reg) begin
      ident_seen_reg  <= 1'b1;
      ident_first_reg <= rd_data;
    end
  end

  ident_fixed_a: assert property (rd_ident |=>
    rd_data[31:24] == IMPL_CODE && rd_data[19:16] == 4'hF)
    else $error("identity implementer or constant nibble wrong");

  ident_variant_a: assert property (rd_ident |=>
    rd_data[23:20] == VARIANT_N)
    else $error("identity variant nibble wrong");

  ident_part_rev_a: assert property (rd_ident |=>
    rd_data[15:4] == PART_NUMBER && rd_data[3:0] == REVISION_M)
    else $error("identity part number or revision wrong");

  ident_shared_a: assert property (ident_rd_d_reg && ident_seen_reg |->
    rd_data == ident_first_reg)
    else $error("identity word differs by state");

  bank_isolated_a: assert property (
    wr_ctrl && !tick_event && sec_state |=> $stable(svc_pending[0]) && $stable(tick_pending[0]))
    else $error("write touched the other bank");

  vect_fields_a: assert property (rd_ctrl |=>
    rd_data[8:0] == $past(active_vector_number) && rd_data[20:12] == $past(vec_sel))
    else $error("vector fields wrong");

  ret_base_a: assert property (rd_ctrl |=>
    rd_data[EPC_B_RETBASE] == ($past(active_count) <= 8'h01))
    else $error("pre-empted flag wrong");

  isr_pend_a: assert property (rd_ctrl |=>
    rd_data[EPC_B_ISR_PEND] == $past(irq_pending))
    else $error("interrupt pending flag wrong");

  nmi_set_a: assert property (ctrl_wr(EPC_B_NMI_SET) |=> nmi_pending)
    else $error("nonmaskable not pended");

  nmi_read_a: assert property (rd_ctrl |=>
    rd_data[EPC_B_NMI_SET] == $past(nmi_pending) && rd_data[EPC_B_NMI_CLR] == 1'b0)
    else $error("nonmaskable read wrong");

  nmi_clear_a: assert property (
    wr_ctrl && wd[EPC_B_NMI_CLR] && !wd[EPC_B_NMI_SET] && !nmi_req |=> !nmi_pending)
    else $error("nonmaskable not cleared");

  nmi_zero_a: assert property (
    wr_ctrl && !wd[EPC_B_NMI_SET] && !wd[EPC_B_NMI_CLR] && !nmi_req |=> $stable(nmi_pending))
    else $error("zero write changed nonmaskable");

  svc_set_a: assert property (
    ctrl_wr(EPC_B_SVC_SET) ##0 (sec_state == 1'b0) |=> svc_pending[0])
    else $error("service call not pended");

  svc_read_a: assert property (ctrl_rd_in(1'b1) |=>
    rd_data[EPC_B_SVC_SET] == $past(svc_pending[1]) && rd_data[EPC_B_SVC_CLR] == 1'b0)
    else $error("service call read wrong");

  svc_only_sw_a: assert property (
    no_svc_set |=> !$rose(svc_pending[0]) && !$rose(svc_pending[1]))
    else $error("service call pended without a write");

  svc_clear_a: assert property (
    wr_ctrl && wd[EPC_B_SVC_CLR] && !wd[EPC_B_SVC_SET] && sec_state |=> !svc_pending[1])
    else $error("service call not cleared");

  tick_set_a: assert property (
    ctrl_wr(EPC_B_TICK_SET) ##0 sec_state |=> tick_pending[1])
    else $error("tick not pended");

  tick_read_a: assert property (ctrl_rd_in(1'b0) |=>
    rd_data[EPC_B_TICK_SET] == $past(tick_pending[0]))
    else $error("tick read wrong");

  tick_clear_a: assert property (
    wr_ctrl && wd[EPC_B_TICK_CLR] && !wd[EPC_B_TICK_SET] && !tick_event && !sec_state
    |=> !tick_pending[0] && rd_data[EPC_B_TICK_CLR] == 1'b0)
    else $error("tick not cleared");

  vect_idle_a: assert property (
    !nmi_pending && !svc_any && !tick_any && !irq_pending |=> pending_vector_number == 9'h000)
    else $error("pending vector not zero when idle");

  vect_nmi_a: assert property (
    nmi_pending && fault_mask_a |=> pending_vector_number == EPC_EXC_NMI)
    else $error("nonmaskable not chosen");

  rsvd_zero_a: assert property (rd_ctrl |=>
    rd_data[EPC_B_RSVD] == 1'b0 && rd_data[24:23] == 2'b00)
    else $error("reserved bits not zero");

  rd_only_once_a: assert property (!bus_req.rd |=> rd_data == 32'h0000_0000)
    else $error("read data stood beyond its cycle");

  // per-bank writes, zero writes, hardware events and the fault mask
  bank_other_a: assert property (
    bank_wr(1'b0) |=> $stable(svc_pending[1]) && $stable(tick_pending[1]))
    else $error("bank zero write touched bank one");

  svc_set_hi_a: assert property (
    bank_wr(1'b1) ##0 wd[EPC_B_SVC_SET] |=> svc_pending[1])
    else $error("service call not pended in bank one");

  svc_zero_a: assert property (
    wr_ctrl && !wd[EPC_B_SVC_SET] && !wd[EPC_B_SVC_CLR] |=> $stable(svc_pending))
    else $error("zero write changed service call");

  tick_zero_a: assert property (
    wr_ctrl && !wd[EPC_B_TICK_SET] && !wd[EPC_B_TICK_CLR] && !tick_event
    |=> $stable(tick_pending))
    else $error("zero write changed tick");

  tick_clr_hi_a: assert property (
    bank_wr(1'b1) ##0 (wd[EPC_B_TICK_CLR] && !wd[EPC_B_TICK_SET] && !tick_event)
    |=> !tick_pending[1])
    else $error("tick not cleared in bank one");

  tick_event_a: assert property (tick_event && !sec_state |=> tick_pending[0])
    else $error("tick event missed its bank");

  nmi_event_a: assert property (nmi_req |=> nmi_pending)
    else $error("nonmaskable request not pended");

  vect_mask_a: assert property (
    !nmi_pending && fault_mask_a |=> pending_vector_number == 9'h000)
    else $error("fault mask did not hide the vector");

endmodule

// file: epc_pkg.sv
// constants and types shared by the exception pending control block
// Overview of operation
// - read-only identity word with fixed fields
// - variant nibble holds major revision, bits 23:20
// - revision nibble bits 3:0, part number 15:4
// - one identity copy shared by both security states
// - service call and tick bits banked per state, nonmaskable bit shared
// - report active and highest pending exception numbers
// - report whether pre-empted exceptions remain active
// - report whether any interrupt is pending
// - write one to bit 31 pends nonmaskable
// - bit 31 reads nonmaskable pending state
// - write one to bit 30 clears nonmaskable
// - write one to bit 28 pends service call
// - bit 28 reads service call pending state
// - service call pends only by software set
// - write one to bit 27 clears service call
// - write one to bit 26 pends tick
// - bit 26 reads tick pending state
// - write-only tick clear bit removes tick pending
// - pending vector zero when none, honours masks
package epc_pkg;

  // ************************************************************
  // register map and field layout
  // ************************************************************
  localparam int         EPC_ADDR_W     = 8;
  localparam int         EPC_VEC_W      = 9;
  localparam logic [7:0] EPC_OFS_IDENT  = 8'h00;
  localparam logic [7:0] EPC_OFS_CTRL   = 8'h04;
  localparam int         EPC_B_NMI_SET  = 31;
  localparam int         EPC_B_NMI_CLR  = 30;
  localparam int         EPC_B_RSVD     = 29;
  localparam int         EPC_B_SVC_SET  = 28;
  localparam int         EPC_B_SVC_CLR  = 27;
  localparam int         EPC_B_TICK_SET = 26;
  localparam int         EPC_B_TICK_CLR = 25;
  localparam int         EPC_B_ISR_PEND = 22;
  localparam int         EPC_VPEND_LSB  = 12;
  localparam int         EPC_B_RETBASE  = 11;
  localparam int         EPC_VACT_LSB   = 0;
  localparam logic [31:0] EPC_RST_WORD  = 32'h0000_0000;

  // identity fields; all values arbitrary except the constant nibble
  localparam logic [7:0]  EPC_IMPL_DEF    = 8'h5A;
  localparam logic [3:0]  EPC_VARIANT_DEF = 4'h2;
  localparam logic [3:0]  EPC_CONST_NIB   = 4'hF;
  localparam logic [11:0] EPC_PART_DEF    = 12'h5C7;
  localparam logic [3:0]  EPC_REV_DEF     = 4'h3;

  // exception numbers of the system exceptions held here
  localparam logic [8:0] EPC_EXC_NMI  = 9'h002;
  localparam logic [8:0] EPC_EXC_SVC  = 9'h00E;
  localparam logic [8:0] EPC_EXC_TICK = 9'h00F;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } epc_bus_req_t;

endpackage

// file: epc_pend_flag.sv
// one pending flag with set and clear inputs
`timescale 1ns/100ps
module epc_pend_flag
  import epc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic set_sw,
  input  wire logic set_hw,
  input  wire logic clr_sw,
  output logic      flag
);

  // set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (set_sw || set_hw) begin
      flag <= 1'b1;
    end else if (clr_sw) begin
      flag <= 1'b0;
    end
  end

endmodule

// file: epc_vector_sel.sv
// picks the highest priority pending enabled exception
`timescale 1ns/100ps
module epc_vector_sel
  import epc_pkg::*;
(
  input  wire logic       nmi_p,
  input  wire logic       svc_p,
  input  wire logic       tick_p,
  input  wire logic       irq_p,
  input  wire logic [8:0] irq_num,
  input  wire logic [7:0] svc_prio,
  input  wire logic [7:0] tick_prio,
  input  wire logic [7:0] irq_prio,
  input  wire logic [7:0] base_prio,
  input  wire logic       fault_mask,
  output logic [8:0]      vec
);

  // lower value is higher priority; ties go to the lower number
  function automatic logic allowed(input logic [7:0] p);
    allowed = !fault_mask && ((base_prio == 8'h00) || (p < base_prio));
  endfunction

  // primary masking deliberately has no effect on this choice
  always_comb begin
    logic [7:0] best;
    logic       found;
    best  = 8'hFF;
    found = 1'b0;
    vec   = 9'h000;
    if (nmi_p) begin
      vec   = EPC_EXC_NMI;
      found = 1'b1;
    end
    if (!found && svc_p && allowed(svc_prio)) begin
      vec   = EPC_EXC_SVC;
      best  = svc_prio;
      found = 1'b1;
    end
    if (!nmi_p && tick_p && allowed(tick_prio) && (!found || tick_prio < best)) begin
      vec   = EPC_EXC_TICK;
      best  = tick_prio;
      found = 1'b1;
    end
    if (!nmi_p && irq_p && allowed(irq_prio) && (!found || irq_prio < best)) begin
      vec   = irq_num;
    end
  end

endmodule

// file: tb_exception_pend_control_regs.sv
// self-checking testbench for the exception pending control registers
`timescale 1ns/100ps
module tb_exception_pend_control_regs;
  import epc_pkg::*;

  // ************************************************************
  // clock, reset and stimulus signals
  // ************************************************************
  logic         sys_clk;
  logic         rst_b;
  epc_bus_req_t bus_req;
  logic [31:0]  rd_data;
  logic         sec_state, nmi_req, tick_event, irq_pending, fault_mask_a;
  logic [8:0]   irq_number, active_vector_number, pending_vector_number;
  logic [7:0]   irq_priority, svc_priority, tick_priority, base_priority_mask, active_count;
  logic         nmi_pending;
  logic [1:0]   svc_pending, tick_pending;
  int           mismatches, tests_run;
  logic         m_nmi;
  logic [1:0]   m_svc, m_tick;
  logic [31:0]  q;

  epc_regs uut (
    .sys_clk              (sys_clk),
    .rst_b                (rst_b),
    .bus_req              (bus_req),
    .rd_data              (rd_data),
    .sec_state            (sec_state),
    .nmi_req              (nmi_req),
    .tick_event           (tick_event),
    .irq_pending          (irq_pending),
    .irq_number           (irq_number),
    .irq_priority         (irq_priority),
    .svc_priority         (svc_priority),
    .tick_priority        (tick_priority),
    .base_priority_mask   (base_priority_mask),
    .fault_mask_a         (fault_mask_a),
    .active_vector_number (active_vector_number),
    .active_count         (active_count),
    .nmi_pending          (nmi_pending),
    .svc_pending          (svc_pending),
    .tick_pending         (tick_pending),
    .pending_vector_number(pending_vector_number)
  );

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // ************************************************************
  // comparison and bus tasks
  // ************************************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t vec got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // model of a control write: set wins over clear in the same word
  task automatic model_wr(input logic [31:0] d, input logic s);
    m_nmi     = (m_nmi & ~d[30]) | d[31];
    m_svc[s]  = (m_svc[s] & ~d[27]) | d[28];
    m_tick[s] = (m_tick[s] & ~d[25]) | d[26];
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic s);
    @(posedge sys_clk);
    bus_req   <= '{a, d, 1'b1, 1'b0};
    sec_state <= s;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    if (a == EPC_OFS_CTRL) model_wr(d, s);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  // ************************************************************
  // expectation functions
  // ************************************************************
  function automatic logic unmasked(input logic [7:0] p);
    return (base_priority_mask == 8'h00) || (p < base_priority_mask);
  endfunction

  function automatic logic [8:0] exp_vec();
    logic [8:0] v;
    logic [8:0] bp;
    v  = 9'h000;
    bp = 9'h1FF;
    if (m_nmi) return EPC_EXC_NMI;
    if (fault_mask_a) return 9'h000;
    if (m_svc != 2'b00 && unmasked(svc_priority)) begin
      v  = EPC_EXC_SVC;
      bp = {1'b0, svc_priority};
    end
    if (m_tick != 2'b00 && unmasked(tick_priority) && {1'b0, tick_priority} < bp) begin
      v  = EPC_EXC_TICK;
      bp = {1'b0, tick_priority};
    end
    if (irq_pending && unmasked(irq_priority) && {1'b0, irq_priority} < bp) v = irq_number;
    return v;
  endfunction

  function automatic logic [31:0] exp_ctrl(input logic s);
    return {m_nmi, 2'b00, m_svc[s], 1'b0, m_tick[s], 3'b000, irq_pending, 1'b0,
            exp_vec(), (active_count <= 8'h01), 2'b00, active_vector_number};
  endfunction

  // let flags and the registered vector settle, then compare everything
  task automatic check_all;
    repeat (2) @(posedge sys_clk);
    #1 chk_vec(pending_vector_number, exp_vec());
    chk_word({27'h0, nmi_pending, svc_pending, tick_pending},
             {27'h0, m_nmi, m_svc, m_tick});
    bus_rd(EPC_OFS_CTRL, q);
    chk_word(q, exp_ctrl(sec_state));
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  logic [31:0] corner [12] = '{32'h8000_0000, 32'h2000_0000, 32'h4000_0000, 32'hC000_0000,
    32'h1000_0000, 32'h0000_0000, 32'h0800_0000, 32'h0800_0000, 32'h0400_0000,
    32'h0200_0000, 32'hFFFF_FFFF, 32'h5A00_0000};
  logic [11:0] corner_bank = 12'b0000_0110_0011;

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    bus_req = '0;
    sec_state = 1'b0;
    nmi_req = 1'b0;
    tick_event = 1'b0;
    irq_pending = 1'b0;
    fault_mask_a = 1'b0;
    irq_number = 9'h010;
    irq_priority = 8'h80;
    svc_priority = 8'h40;
    tick_priority = 8'h60;
    base_priority_mask = 8'h00;
    active_vector_number = 9'h000;
    active_count = 8'h00;
    mismatches = 0;
    tests_run = 0;
    m_nmi = 1'b0;
    m_svc = 2'b00;
    m_tick = 2'b00;
    void'($urandom(87));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;

    // identity word: same in both states, writes ignored, unmapped reads zero
    for (int s = 0; s < 2; s++) begin
      bus_wr(EPC_OFS_IDENT, 32'hFFFF_FFFF, s[0]);
      bus_rd(EPC_OFS_IDENT, q);
      chk_word(q, {EPC_IMPL_DEF, EPC_VARIANT_DEF, EPC_CONST_NIB, EPC_PART_DEF,
                   EPC_REV_DEF});
      @(posedge sys_clk);
      #1 chk_word(rd_data, 32'h0000_0000); // read data stands one cycle only
    end
    bus_rd(8'h08, q);
    chk_word(q, 32'h0000_0000); // unmapped address reads zero
    $display("test identity done");

    // corner writes: set, clear, set with clear, banks apart, reserved bit
    for (int i = 0; i < 12; i++) begin
      bus_wr(EPC_OFS_CTRL, corner[i], corner_bank[i]);
      check_all();
    end
    $display("test corners done");

    // hardware events, and a tick event meeting a tick clear in one cycle
    @(posedge sys_clk);
    nmi_req <= 1'b1;
    tick_event <= 1'b1;
    bus_req <= '{EPC_OFS_CTRL, 32'h4200_0000, 1'b1, 1'b0};
    sec_state <= 1'b0;
    @(posedge sys_clk);
    nmi_req <= 1'b0;
    tick_event <= 1'b0;
    bus_req.wr <= 1'b0;
    m_nmi = 1'b1;
    m_tick[0] = 1'b1;
    check_all();
    $display("test events done");

    // random traffic over status inputs and control writes
    for (int i = 0; i < 250; i++) begin
      @(posedge sys_clk);
      irq_pending <= 1'($urandom);
      irq_number <= 9'h010 + 9'($urandom % 480);
      irq_priority <= 8'($urandom);
      svc_priority <= 8'($urandom);
      tick_priority <= 8'($urandom);
      base_priority_mask <= ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
      fault_mask_a <= ($urandom % 8 == 0);
      active_vector_number <= 9'($urandom);
      active_count <= 8'($urandom % 4);
      bus_wr(EPC_OFS_CTRL, $urandom & $urandom, 1'($urandom));
      check_all();
    end
    $display("test random done");

    // reset in mid-run: flags, vector and read data all drop to zero
    @(posedge sys_clk);
    rst_b <= 1'b0;
    @(posedge sys_clk);
    #1 chk_word(rd_data, 32'h0000_0000); // read data cleared by reset
    chk_vec(pending_vector_number, 9'h000); // vector cleared by reset
    chk_word({27'h0, nmi_pending, svc_pending, tick_pending}, 32'h0000_0000);
    m_nmi = 1'b0;
    m_svc = 2'b00;
    m_tick = 2'b00;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    bus_wr(EPC_OFS_CTRL, 32'h1400_0000, 1'b1);
    check_all();
    $display("test reset done");
    tally_and_finish();
  end

  // watchdog well beyond the expected length of the run
  initial begin
    #(25 * 8000);
    mismatches++;
    tally_and_finish();
  end
endmodule
